// File: pkg/fa_pkg.sv
/*
  Constants and types for the scan-port flash access block.
  Assumes a 100 MHz system clock and a test clock well below it.
*/
`default_nettype none
package fa_pkg;
  // Widths
  localparam int ADDR_W = 15;
  localparam int SR_W   = 20;
  localparam int RES_W  = 18;
  localparam int CNT_W  = 20;
  // Field positions in the shifted command and payload
  localparam int OP_BIT    = 19;
  localparam int PAY_MSB   = 17;
  localparam int BYTE_LSB  = 10;
  localparam int ADDR_LSB  = 3;
  // Stored scale bits: one-shot select, sense always on, prescaler
  localparam int ONE_SHOT_STROBE_SELECT_POS  = 5;
  localparam int SENSE_ALWAYS_ON_POS  = 4;
  // Indirect register selects held in the instruction register
  localparam logic [1:0] SEL_CTRL  = 2'h0;
  localparam logic [1:0] SEL_DATA  = 2'h1;
  localparam logic [1:0] SEL_ADDR  = 2'h2;
  localparam logic [1:0] SEL_SCALE = 2'h3;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  // Mode codes of the control register
  localparam logic [3:0] WMODE_STORE  = 4'h0;
  localparam logic [3:0] WMODE_PROG   = 4'h1;
  localparam logic [3:0] WMODE_ERASE  = 4'h2;
  localparam logic [3:0] RMODE_STORE  = 4'h0;
  localparam logic [3:0] RMODE_BLOCK  = 4'h1;
  localparam logic [3:0] RMODE_SINGLE = 4'h2;
  // Keys and addresses
  localparam logic [7:0] ERASE_KEY = 8'hA5;
  localparam logic [3:0] SCL_LOCKED = 4'hF;
  localparam logic [ADDR_W-1:0] ALL_ERASE_LO = 15'h7DFE;
  localparam logic [ADDR_W-1:0] RESERVED_LO  = 15'h7E00;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ONESHOT_NS    = 50;
  localparam int ONESHOT_CYC   = (ONESHOT_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : ONESHOT_NS / CLK_PERIOD_NS;
  localparam int PROG_TICKS    = 1;
  localparam int ERASE_TICKS   = 10;
  // Test access port states, Gray steps along the data path
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
    SH_DR = 4'h6, EX1_DR = 4'h7, PA_DR = 4'h5, EX2_DR = 4'h4,
    UP_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SH_IR = 4'hE,
    EX1_IR = 4'hA, PA_IR = 4'hB, EX2_IR = 4'h9, UP_IR = 4'h8
  } tap_type;
  typedef enum logic {OP_IDLE = 1'b0, OP_RUN = 1'b1} op_type;
  typedef enum logic [1:0] {K_READ = 2'h0, K_PROG = 2'h1, K_ERASE = 2'h3} kind_type;
endpackage
`default_nettype wire

// File: src/flash_access.sv
/*
  Scan-port flash access logic: a test access port whose indirect
  registers drive byte reads, byte programs and erases of a flash macro.
  Assumes the macro reports data and fail on the cycle a strobe ends.
*/
// Behaviour
// - Write mode 0000: data port write only stores the byte.
// - Write mode 0001: program byte at address, then address plus one.
// - Write mode 0010: key A5 erases page to FF; address unchanged.
// - Erase at 7DFE or 7DFF erases all user flash, not 7E00-7FFF.
// - Read mode 0000: data port read returns stored value, no access.
// - Read mode 0001: each data read starts a byte read when idle.
// - Read mode 0010: start only if idle and previous result fetched.
// - Data port is data byte 9:2, fail bit 1, busy bit 0.
// - Fail reads 1 when the previous flash operation failed.
// - Busy is 1 during a request; accesses then are held, not started.
// - Scale bit 7 picks one-cycle or 50 ns read strobe.
// - Scale bit 6 keeps sense amplifiers always on, else only reads.
// - Scale bits 5 and 4 read zero and ignore writes.
// - Prescaler 1111 refuses every read, program and erase.
// - Command bits 19:18: 0x polls, 10 reads, 11 writes.
// - Capture gives zero, read result in 18:1, busy in bit 0.
// - Commands while busy are held and start once busy reads low.
`timescale 1ns/1ps
`default_nettype none
module flash_access (
  // System
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  // Test port pins
  input  wire logic                        tck,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output var  logic                        tdo,
  output var  logic                        tdo_oe_n,
  // Flash macro
  output var  logic [fa_pkg::ADDR_W-1:0]   flash_addr,
  output var  logic [7:0]                  flash_wdata,
  output var  logic                        flash_rd,
  output var  logic                        flash_prog,
  output var  logic                        flash_erase,
  output var  logic                        flash_erase_all,
  output var  logic                        flash_sense_en,
  input  wire logic [7:0]                  flash_rdata,
  input  wire logic                        flash_fail
);
  import fa_pkg::*;

  typedef struct packed {
    logic             tck_m, tck_s, tck_p, tms_m, tms_s, tdi_m, tdi_s;
    tap_type          tap;
    logic [1:0]       ir, ir_sh;
    logic [SR_W-1:0]  dr_sh;
    logic [RES_W-1:0] rd_result;
    logic             pend, pend_wr;
    logic [1:0]       pend_ir;
    logic [RES_W-1:0] pend_pay;
    logic [7:0]       mode, data;
    logic             fail, fresh;
    logic [ADDR_W-1:0] addr;
    logic [5:0]       scale;
    op_type           op;
    kind_type         kind;
    logic [CNT_W-1:0] cnt;
    logic             tdo, tdo_oe_n;
    logic [ADDR_W-1:0] fl_addr;
    logic [7:0]       fl_wdata;
    logic             fl_rd, fl_prog, fl_erase, fl_erase_all, fl_sense;
  } state_type;

  state_type        q_reg, q_next;
  logic             rise, fall, busy, ex_go, ex_wr, start, all_erase;
  logic [1:0]       ex_ir;
  logic [RES_W-1:0] ex_pay;
  kind_type         st_kind;

  // One step of the standard access port graph
  function automatic tap_type tap_step(input tap_type s, input logic m);
    tap_type n;
    case (s)
      TLR:     n = m ? TLR : RTI;
      RTI:     n = m ? SEL_DR : RTI;
      SEL_DR:  n = m ? SEL_IR : CAP_DR;
      CAP_DR:  n = m ? EX1_DR : SH_DR;
      SH_DR:   n = m ? EX1_DR : SH_DR;
      EX1_DR:  n = m ? UP_DR : PA_DR;
      PA_DR:   n = m ? EX2_DR : PA_DR;
      EX2_DR:  n = m ? UP_DR : SH_DR;
      UP_DR:   n = m ? SEL_DR : RTI;
      SEL_IR:  n = m ? TLR : CAP_IR;
      CAP_IR:  n = m ? EX1_IR : SH_IR;
      SH_IR:   n = m ? EX1_IR : SH_IR;
      EX1_IR:  n = m ? UP_IR : PA_IR;
      PA_IR:   n = m ? EX2_IR : PA_IR;
      EX2_IR:  n = m ? UP_IR : SH_IR;
      UP_IR:   n = m ? SEL_DR : RTI;
      default: n = TLR;
    endcase
    return n;
  endfunction

  // Whole next state; the test clock is only sampled, never used as a clock
  always_comb
  begin
    q_next = q_reg;
    ex_go = 1'b0;
    ex_wr = 1'b0;
    ex_ir = SEL_CTRL;
    ex_pay = '0;
    start = 1'b0;
    st_kind = K_READ;
    all_erase = 1'b0;
    // Two flops on every test port pin before anything looks at it
    q_next.tck_m = tck;
    q_next.tck_s = q_reg.tck_m;
    q_next.tck_p = q_reg.tck_s;
    q_next.tms_m = tms;
    q_next.tms_s = q_reg.tms_m;
    q_next.tdi_m = tdi;
    q_next.tdi_s = q_reg.tdi_m;
    rise = q_reg.tck_s & ~q_reg.tck_p;
    fall = ~q_reg.tck_s & q_reg.tck_p;
    busy = (q_reg.op == OP_RUN);

    // Capture and shift on the rising test edge
    if (rise)
    begin
      q_next.tap = tap_step(q_reg.tap, q_reg.tms_s);
      case (q_reg.tap)
        TLR:     q_next.ir = SEL_CTRL;
        CAP_DR:  q_next.dr_sh = {1'b0, q_reg.rd_result, busy};
        SH_DR:   q_next.dr_sh = {q_reg.tdi_s, q_reg.dr_sh[SR_W-1:1]};
        CAP_IR:  q_next.ir_sh = IR_CAPTURE;
        SH_IR:   q_next.ir_sh = {q_reg.tdi_s, q_reg.ir_sh[1]};
        default: q_next.tap = tap_step(q_reg.tap, q_reg.tms_s);
      endcase
      // held command starts once busy is captured low
      if (q_reg.tap == CAP_DR && q_reg.pend && !busy)
      begin
        ex_go = 1'b1;
        ex_wr = q_reg.pend_wr;
        ex_ir = q_reg.pend_ir;
        ex_pay = q_reg.pend_pay;
        q_next.pend = 1'b0;
      end
    end

    // Output and update on the falling test edge
    if (fall)
    begin
      q_next.tdo_oe_n = 1'b1;
      if (q_reg.tap == SH_DR)
      begin
        q_next.tdo = q_reg.dr_sh[0];
        q_next.tdo_oe_n = 1'b0;
      end
      if (q_reg.tap == SH_IR)
      begin
        q_next.tdo = q_reg.ir_sh[0];
        q_next.tdo_oe_n = 1'b0;
      end
      if (q_reg.tap == UP_IR)
        q_next.ir = q_reg.ir_sh;
      // opcode 1x acts, 0x is a poll
      if (q_reg.tap == UP_DR && q_reg.dr_sh[OP_BIT])
      begin
        if (busy)
        begin
          q_next.pend = 1'b1;
          q_next.pend_wr = q_reg.dr_sh[OP_BIT-1];
          q_next.pend_ir = q_reg.ir;
          q_next.pend_pay = q_reg.dr_sh[PAY_MSB:0];
        end
        else
        begin
          ex_go = 1'b1;
          ex_wr = q_reg.dr_sh[OP_BIT-1];
          ex_ir = q_reg.ir;
          ex_pay = q_reg.dr_sh[PAY_MSB:0];
        end
      end
    end

    // Indirect register writes, payload taken from the top
    if (ex_go && ex_wr)
    begin
      case (ex_ir)
        SEL_CTRL:  q_next.mode = ex_pay[PAY_MSB -: 8];
        SEL_ADDR:  q_next.addr = ex_pay[PAY_MSB:ADDR_LSB];
        SEL_SCALE: q_next.scale = {ex_pay[PAY_MSB -: 2], ex_pay[BYTE_LSB +: 4]};
        default:
        begin
          q_next.data = ex_pay[PAY_MSB -: 8];
          if (q_reg.mode[7:4] == WMODE_PROG)
          begin
            start = 1'b1;
            st_kind = K_PROG;
          end
          if (q_reg.mode[7:4] == WMODE_ERASE && ex_pay[PAY_MSB -: 8] == ERASE_KEY)
          begin
            start = 1'b1;
            st_kind = K_ERASE;
          end
        end
      endcase
    end

    // Indirect register reads, result right-justified
    if (ex_go && !ex_wr)
    begin
      case (ex_ir)
        SEL_CTRL:  q_next.rd_result = {10'h000, q_reg.mode};
        SEL_ADDR:  q_next.rd_result = {3'h0, q_reg.addr};
        SEL_SCALE: q_next.rd_result = {10'h000, q_reg.scale[5:4], 2'h0, q_reg.scale[3:0]};
        default:
        begin
          q_next.rd_result = {8'h00, q_reg.data, q_reg.fail, busy};
          q_next.fresh = 1'b0;
          if (q_reg.mode[3:0] == RMODE_BLOCK)
            start = 1'b1;
          // single reads skip while a result waits
          if (q_reg.mode[3:0] == RMODE_SINGLE && !q_reg.fresh)
            start = 1'b1;
        end
      endcase
    end

    // Launch, refused when locked or for an erase aimed at the reserved area
    all_erase = (q_reg.addr[ADDR_W-1:1] == ALL_ERASE_LO[ADDR_W-1:1]);
    if (start)
    begin
      if (q_reg.scale[3:0] == SCL_LOCKED
          || (st_kind == K_ERASE && q_reg.addr >= RESERVED_LO))
        q_next.fail = 1'b1;
      else
      begin
        q_next.op = OP_RUN;
        q_next.kind = st_kind;
        q_next.fail = 1'b0;
        q_next.fl_addr = q_reg.addr;
        q_next.fl_wdata = q_next.data;
        case (st_kind)
          K_PROG:
          begin
            q_next.fl_prog = 1'b1;
            q_next.cnt = CNT_W'((PROG_TICKS << q_reg.scale[3:0]) - 1);
          end
          K_ERASE:
          begin
            q_next.fl_erase = 1'b1;
            // whole user space, reserved area left alone
            q_next.fl_erase_all = all_erase;
            q_next.cnt = CNT_W'((ERASE_TICKS << q_reg.scale[3:0]) - 1);
          end
          default:
          begin
            q_next.fl_rd = 1'b1;
            // strobe width from the one-shot select
            q_next.cnt = q_reg.scale[ONE_SHOT_STROBE_SELECT_POS] ? CNT_W'(ONESHOT_CYC - 1) : '0;
          end
        endcase
      end
    end

    // Running operation; program and erase time scale with the prescaler
    if (q_reg.op == OP_RUN)
    begin
      if (q_reg.cnt != '0)
        q_next.cnt = q_reg.cnt - 1'b1;
      else
      begin
        q_next.op = OP_IDLE;
        q_next.fl_rd = 1'b0;
        q_next.fl_prog = 1'b0;
        q_next.fl_erase = 1'b0;
        q_next.fl_erase_all = 1'b0;
        q_next.fail = flash_fail;
        if (q_reg.kind == K_READ)
        begin
          q_next.data = flash_rdata;
          q_next.fresh = 1'b1;
        end
        if (q_reg.kind == K_PROG)
          q_next.addr = q_reg.addr + 1'b1;
      end
    end

    // sense amplifiers always on or only while reading
    q_next.fl_sense = q_next.scale[SENSE_ALWAYS_ON_POS]
                      | (q_next.op == OP_RUN && q_next.kind == K_READ);
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      q_reg <= '0;
    else if (ce)
      q_reg <= q_next;
  end

  // Outputs straight from the state register
  assign tdo             = q_reg.tdo;
  assign tdo_oe_n        = q_reg.tdo_oe_n;
  assign flash_addr      = q_reg.fl_addr;
  assign flash_wdata     = q_reg.fl_wdata;
  assign flash_rd        = q_reg.fl_rd;
  assign flash_prog      = q_reg.fl_prog;
  assign flash_erase     = q_reg.fl_erase;
  assign flash_erase_all = q_reg.fl_erase_all;
  assign flash_sense_en  = q_reg.fl_sense;

  // Checks; a frozen clock enable suspends them
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !ce);

  AST_STORE_ONLY: assert property (
    ex_go && ex_wr && ex_ir == SEL_DATA && q_reg.mode[7:4] == WMODE_STORE
    |=> q_reg.op == OP_IDLE && q_reg.data == $past(ex_pay[PAY_MSB -: 8]))
    else $error("store-only write started an operation");
  AST_PROG_STEP: assert property (
    $fell(q_reg.fl_prog) |-> q_reg.addr == ADDR_W'($past(q_reg.addr) + 1'b1))
    else $error("address did not step after program");
  AST_ERASE_KEY: assert property (
    ex_go && ex_wr && ex_ir == SEL_DATA && ex_pay[PAY_MSB -: 8] != ERASE_KEY
    |=> !q_reg.fl_erase && $stable(q_reg.addr))
    else $error("erase without key");
  AST_ALL_ERASE: assert property (
    q_reg.fl_erase_all |-> q_reg.fl_erase
    && q_reg.fl_addr[ADDR_W-1:1] == ALL_ERASE_LO[ADDR_W-1:1])
    else $error("whole erase at wrong address");
  AST_READ_STORE: assert property (
    ex_go && !ex_wr && ex_ir == SEL_DATA && q_reg.mode[3:0] == RMODE_STORE
    |=> !q_reg.fl_rd)
    else $error("store-only read touched flash");
  AST_SINGLE_SKIP: assert property (
    ex_go && !ex_wr && ex_ir == SEL_DATA && q_reg.mode[3:0] == RMODE_SINGLE
    && q_reg.fresh |=> !q_reg.fl_rd && !q_reg.fresh)
    else $error("surplus read started");
  AST_BUSY_COVERS: assert property (
    (q_reg.fl_rd || q_reg.fl_prog || q_reg.fl_erase) |-> q_reg.op == OP_RUN)
    else $error("strobe without busy");
  AST_ONESHOT: assert property (
    $rose(q_reg.fl_rd) && q_reg.scale[ONE_SHOT_STROBE_SELECT_POS] |-> q_reg.fl_rd[*5] ##1 !q_reg.fl_rd)
    else $error("one-shot read strobe wrong width");
  AST_LOCKED: assert property (
    start && q_reg.scale[3:0] == SCL_LOCKED |=> q_reg.op == OP_IDLE && q_reg.fail)
    else $error("locked prescaler did not refuse");

  COV_PROG: cover property ($fell(q_reg.fl_prog));
  COV_ERASE_ALL: cover property ($rose(q_reg.fl_erase_all));
  COV_READ: cover property ($fell(q_reg.fl_rd) ##1 q_reg.fresh);
  COV_HELD: cover property (q_reg.pend && ex_go);
endmodule
`default_nettype wire

// File: bench/jtag_host.sv
/*
  Test port host model: drives the scan pins and shifts IR and DR frames.
  Assumes the block samples the pins with its own faster system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
  // Scan pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  // Link clock stands low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 125 ns link cycle; pins change only while the link clock is low
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo;
    #62.5 tck = 1'b0;
  endtask
  // Five ones reach the reset state from anywhere, then idle
  task automatic reset_tap;
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // Two-bit instruction, shifted low bit first
  task automatic ir(input logic [1:0] v);
    logic q;
    tick(1'b1, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, v[0], q);
    tick(1'b1, v[1], q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // Full 20-bit data frame, low bit first in and out
  task automatic dr(input logic [19:0] din, output logic [19:0] dout);
    logic q;
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < 20; i++)
      tick(i == 19, din[i], dout[i]);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // opcode on top, short payloads left-justified to bit 17
  task automatic cmd(input logic [1:0] sel, input logic [1:0] op, input logic [17:0] pay,
                     input int w, output logic [19:0] q);
    ir(sel);
    dr({op, pay << (18 - w)}, q);
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
/*
  Self-checking bench for the scan-port flash access block.
  Assumes a flash macro answering with a byte derived from the address.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fa_pkg::*;
  typedef struct packed {
    logic [3:0] wm;
    logic [14:0] a;
    logic [7:0] d;
    logic np;
    logic ne;
    logic all;
  } row_type;
  logic clock, nrst, ce, tck, tms, tdi, tdo, tdo_oe_n;
  logic [ADDR_W-1:0] flash_addr, la;
  logic [7:0] flash_wdata, flash_rdata, ld;
  logic flash_rd, flash_prog, flash_erase, flash_erase_all, flash_sense_en, flash_fail, lall;
  logic [2:0] s;
  logic [19:0] q;
  int bad_count, cmp_count;
  int cnt[3], run[3], wid[3];
  row_type rows [6] = '{'{4'h0, 15'h0010, 8'h3C, 0, 0, 0}, '{4'h1, 15'h0010, 8'h3C, 1, 0, 0},
    '{4'h2, 15'h0010, 8'hA5, 0, 1, 0}, '{4'h2, 15'h0010, 8'h5A, 0, 0, 0},
    '{4'h2, 15'h7DFE, 8'hA5, 0, 1, 1}, '{4'h2, 15'h7DFF, 8'hA5, 0, 1, 1}};
  // Flash macro: read byte is a fixed function of the address
  assign flash_rdata = flash_addr[7:0] ^ 8'h5A;
  assign s = {flash_erase, flash_prog, flash_rd};
  initial clock = 1'b0;
  always #5 clock = ~clock;
  flash_access dut (.clock(clock), .nrst(nrst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rd(flash_rd), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_erase_all(flash_erase_all), .flash_sense_en(flash_sense_en),
    .flash_rdata(flash_rdata), .flash_fail(flash_fail));
  jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // Strobe counts and widths, plus the target of the last program or erase
  always @(posedge clock)
  begin
    for (int k = 0; k < 3; k++)
      if (s[k])
      begin
        if (run[k] == 0) cnt[k]++;
        run[k]++;
      end
      else if (run[k] != 0)
      begin
        wid[k] = run[k];
        run[k] = 0;
      end
    if (flash_prog | flash_erase)
    begin
      la = flash_addr;
      ld = flash_wdata;
      lall = flash_erase_all;
    end
  end
  task automatic test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Poll until busy reads low; the last capture carries the read result
  task automatic wait_idle(output logic [19:0] o);
    for (int i = 0; i < 300; i++)
    begin
      host.dr(20'h0, o);
      if (o[0] === 1'b0) return;
    end
    bad_count++;
    $display("BAD %0t busy never cleared", $time);
    test_done();
  endtask
  task automatic wr(input logic [1:0] sel, input logic [17:0] pay, input int w);
    logic [19:0] o;
    host.cmd(sel, 2'b11, pay, w, o);
    wait_idle(o);
  endtask
  task automatic rd(input logic [1:0] sel, output logic [19:0] o);
    host.cmd(sel, 2'b10, 18'h0, 18, o);
    wait_idle(o);
  endtask
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    flash_fail = 1'b0;
    cnt = '{0, 0, 0};
    run = '{0, 0, 0};
    #15 chk({flash_rd, flash_prog, flash_erase, flash_erase_all, flash_sense_en}, 0);
    @(posedge clock);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clock);
    host.reset_tap();
    // Register reset values
    rd(SEL_CTRL, q);
    chk(q, 0);
    rd(SEL_SCALE, q);
    chk(q, 0);
    // prescaler loaded before any flash operation
    wr(SEL_SCALE, 8'h01, 8);
    // only defined mode codes in every row
    foreach (rows[i])
    begin
      wr(SEL_CTRL, {rows[i].wm, 4'h0}, 8);
      wr(SEL_ADDR, rows[i].a, 15);
      cnt = '{0, 0, 0};
      wr(SEL_DATA, rows[i].d, 8);
      chk(cnt[1], rows[i].np);
      chk(cnt[2], rows[i].ne);
      if (rows[i].np)
      begin
        chk({la, ld}, {rows[i].a, rows[i].d});
        chk(wid[1], PROG_TICKS << 1);
      end
      if (rows[i].ne)
      begin
        chk({la, lall}, {rows[i].a, rows[i].all});
        chk(wid[2], ERASE_TICKS << 1);
      end
      rd(SEL_DATA, q);
      chk(q[19:1], {9'h0, rows[i].d, 2'b00});
      chk(cnt[0], 0);
    end
    // Two programs in a row land on consecutive addresses
    wr(SEL_CTRL, 8'h10, 8);
    wr(SEL_ADDR, 15'h0020, 15);
    wr(SEL_DATA, 8'h11, 8);
    wr(SEL_DATA, 8'h22, 8);
    chk({la, ld}, {15'h0021, 8'h22});
    // Block reads, one-cycle strobe, sense only while reading
    wr(SEL_CTRL, 8'h01, 8);
    wr(SEL_ADDR, 15'h0030, 15);
    cnt = '{0, 0, 0};
    rd(SEL_DATA, q);
    rd(SEL_DATA, q);
    chk(cnt[0], 2);
    chk(q[10:3], 8'h6A);
    chk(wid[0], 1);
    chk(flash_sense_en, 1'b0);
    wr(SEL_SCALE, 8'hF1, 8);
    rd(SEL_SCALE, q);
    chk(q[8:1], 8'hC1);
    // Single reads skip the surplus access; one-shot strobe, sense held on
    wr(SEL_CTRL, 8'h02, 8);
    cnt = '{0, 0, 0};
    rd(SEL_DATA, q);
    rd(SEL_DATA, q);
    chk(cnt[0], 1);
    chk(wid[0], ONESHOT_CYC);
    chk(flash_sense_en, 1'b1);
    // Failure flag follows the macro
    wr(SEL_CTRL, 8'h10, 8);
    @(posedge clock);
    #1 flash_fail = 1'b1;
    wr(SEL_DATA, 8'h33, 8);
    rd(SEL_DATA, q);
    chk(q[2:1], 2'b10);
    @(posedge clock);
    #1 flash_fail = 1'b0;
    wr(SEL_DATA, 8'h44, 8);
    rd(SEL_DATA, q);
    chk(q[2:1], 2'b00);
    // Locked prescaler refuses programs and reads
    wr(SEL_SCALE, 8'h0F, 8);
    wr(SEL_CTRL, 8'h11, 8);
    cnt = '{0, 0, 0};
    wr(SEL_DATA, 8'h55, 8);
    rd(SEL_DATA, q);
    chk(q[2], 1'b1);
    chk({cnt[0], cnt[1]}, 0);
    // A write during a long erase waits until busy is seen low
    wr(SEL_SCALE, 8'h08, 8);
    wr(SEL_CTRL, 8'h20, 8);
    wr(SEL_ADDR, 15'h0040, 15);
    cnt = '{0, 0, 0};
    host.cmd(SEL_DATA, 2'b11, 8'hA5, 8, q);
    host.dr({2'b11, 8'hA5, 10'h0}, q);
    chk(cnt[2], 1);
    host.dr(20'h0, q);
    chk(q[0], 1'b1);
    wait_idle(q);
    wait_idle(q);
    chk(cnt[2], 2);
    // Clock enable low freezes a running erase past its normal length
    host.cmd(SEL_DATA, 2'b11, 8'hA5, 8, q);
    @(posedge clock);
    #1 ce = 1'b0;
    repeat (3000) @(posedge clock);
    chk(flash_erase, 1'b1);
    #1 ce = 1'b1;
    wait_idle(q);
    chk(cnt[2], 3);
    // Reset after the erase completes returns the registers to zero
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clock);
    chk({flash_rd, flash_prog, flash_erase, flash_erase_all, flash_sense_en}, 0);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clock);
    host.reset_tap();
    rd(SEL_SCALE, q);
    chk(q, 0);
    chk(tdo_oe_n, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
